// file: bench/psr_sta_model.sv
/*
 Station manager model: single-word reads and writes of the status word.
 Assumes the register decoder runs on the same clock as clk_in.
*/
`timescale 1ns/1ns
module psr_sta_model
	import psr_pkg::*;
(
	input wire logic clk_in,
	output logic [4:0] addr_out,
	output logic rd_out,
	output logic wr_out,
	output logic [15:0] wdata_out,
	input wire logic [15:0] rdata_in
);
	// ==========================================================
	// Idle bus
	// A released bus shows another address and churned data, never 0x01
	initial begin
		addr_out = 5'h1e;
		rd_out = 1'h0;
		wr_out = 1'h0;
		wdata_out = 16'h0000;
	end

	// ==========================================================
	// Accesses
	task automatic wr(input psr_word_type d);
		@(posedge clk_in);
		addr_out <= 5'h01;
		wr_out <= 1'h1;
		wdata_out <= d & 16'hf87f;
		@(posedge clk_in);
		wr_out <= 1'h0;
		addr_out <= 5'h1e;
		wdata_out <= ~d;
	endtask

	// Read data is taken one edge after the sampling edge
	task automatic rd(output psr_word_type d);
		@(posedge clk_in);
		addr_out <= 5'h01;
		rd_out <= 1'h1;
		@(posedge clk_in);
		rd_out <= 1'h0;
		addr_out <= 5'h1e;
		@(posedge clk_in);
		#1 d = rdata_in;
	endtask
endmodule

// file: bench/tb_phy_status_register.sv
/*
 Bench of the PHY status word: fixed bits, override writes and flags.
 Assumes the station manager model performs every register access.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
	fail_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_phy_status_register
	import psr_pkg::*;
;
	logic clk, rst_n, rd, wr, ovr, an_en, an_done, rf, lk, jab, jen, pre;
	logic [4:0] addr;
	logic [15:0] wdata, rdata;
	logic [3:0] mode, rsv;
	psr_cw_type cw;
	logic [31:0] seed;
	int fail_count, n_compared;

	always #4 clk = ~clk;

	psr_status_reg dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
		.REG_ADDR_IN(addr), .REG_RD_IN(rd), .REG_WR_IN(wr),
		.REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .OVERRIDE_EN_IN(ovr),
		.AN_ENABLE_IN(an_en), .AN_DONE_IN(an_done), .REMOTE_FAULT_IN(rf),
		.LINK_OK_IN(lk), .JABBER_IN(jab), .JABBER_DET_EN_IN(jen),
		.MODE_ABILITY_OUT(mode), .PREAMBLE_SUPPRESS_OUT(pre),
		.RESERVED_TEST_OUT(rsv));
	psr_sta_model sta (.clk_in(clk), .addr_out(addr), .rd_out(rd),
		.wr_out(wr), .wdata_out(wdata), .rdata_in(rdata));

	// ==========================================================
	// Expectations
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction

	// Flags f are {negotiation done, remote fault, link, jabber}
	function automatic psr_word_type exp_word(input psr_cw_type c,
		input logic [3:0] f);
		return {1'h0, c[8:5], 4'h0, c[0], f[3:2], 1'h1, f[1:0], 1'h1};
	endfunction

	task automatic check_word(input logic [3:0] f, input string n);
		psr_word_type w;
		sta.rd(w);
		`CHK(n, exp_word(cw, f), w)
		`CHK("mode", cw[8:5], mode)
		`CHK("preamble", cw[0], pre)
		`CHK("reserved", 4'h0, rsv)
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		clk = 1'h0;
		rst_n = 1'h0;
		{ovr, an_done, rf, jab} = 4'h0;
		{an_en, lk, jen} = 3'h7;
		seed = 32'he;
		cw = 9'h1e0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		check_word(4'h2, "reset");
		seed = xs(seed);
		sta.wr(seed[15:0]);
		check_word(4'h2, "locked");
		$display("test defaults and lock done");
		@(posedge clk) ovr <= 1'h1;
		for (int i = 0; i < 12; i++) begin
			seed = xs(seed);
			if (i < 2) seed[15:0] = i ? 16'hffff : 16'h0040;
			sta.wr(seed[15:0]);
			cw = {seed[14:11], 4'h0, seed[6]};
			check_word(4'h2, "override");
		end
		$display("test override done");
		@(posedge clk) jab <= 1'h1;
		@(posedge clk) jab <= 1'h0;
		check_word(4'h3, "jabber");
		check_word(4'h2, "jabber clear");
		@(posedge clk) rf <= 1'h1;
		@(posedge clk) rf <= 1'h0;
		check_word(4'h6, "fault");
		check_word(4'h2, "fault clear");
		@(posedge clk) lk <= 1'h0;
		@(posedge clk) lk <= 1'h1;
		check_word(4'h0, "link drop");
		check_word(4'h2, "link back");
		@(posedge clk) an_done <= 1'h1;
		@(posedge clk) an_done <= 1'h0;
		check_word(4'ha, "an done");
		check_word(4'h2, "an clear");
		@(posedge clk) an_en <= 1'h0;
		an_done <= 1'h1;
		check_word(4'h2, "an off");
		@(posedge clk) jen <= 1'h0;
		@(posedge clk) jab <= 1'h1;
		@(posedge clk) jab <= 1'h0;
		check_word(4'h2, "jabber off");
		$display("test sticky flags done");
		conclude();
	end

	// About 40 accesses of up to three cycles each; leave wide margin
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		conclude();
	end
endmodule

// file: verilog/psr_defines.svh
/*
 Constants of the PHY status word: address, bit positions, fixed values
 and reset values. Holds definitions only.
*/
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH

// ==========================================================
// Address and width
`define PSR_ADDR 5'h01
`define PSR_ADDR_W 5
`define PSR_WORD_W 16

// ==========================================================
// Field positions
`define PSR_T4_BIT 15
`define PSR_CW_HI 14
`define PSR_CW_LO 6
`define PSR_ANC_BIT 5
`define PSR_RF_BIT 4
`define PSR_ANA_BIT 3
`define PSR_LINK_BIT 2
`define PSR_JAB_BIT 1
`define PSR_EXT_BIT 0

// ==========================================================
// Fixed and reset values
`define PSR_T4_VALUE 1'h0
`define PSR_ANA_VALUE 1'h1
`define PSR_EXT_VALUE 1'h1
`define PSR_RSV_READ 4'h0
// Bits 14:6 of the word: abilities one, reserved and preamble zero
`define PSR_CW_RESET 9'h1e0
`define PSR_RDATA_RESET 16'h0000

`endif

// file: verilog/psr_pkg.sv
/*
 Types shared by the PHY status word modules.
 Assumes psr_defines.svh for the numeric constants.
*/
package psr_pkg;
	typedef enum logic {PSR_LATCH_HIGH, PSR_LATCH_LOW} psr_latch_type;
	typedef logic [15:0] psr_word_type;
	typedef logic [8:0] psr_cw_type;
endpackage

// file: verilog/psr_status_reg.sv
/*
 Management status word of a 10/100 PHY: ability bits, override-writable
 bits and latching status flags, read and written by the management frame
 decoder one register access at a time.
 Assumes the decoder gives one-cycle read and write strobes with address
 and data on the core clock, and that the override enable, negotiation,
 link and jabber inputs come from logic on the same clock.
*/
// Behaviour
// [R01] 16-bit word at address 0x01, reached only through management access.
// [R02] Reset loads every bit with its default.
// [R03] Bit 15 reads zero and cannot be written.
// [R04] Ability bits 14:11 reset to one.
// [R05] Override enable low: writes to override-writable bits are ignored.
// [R06] Override enable high: writes update bits 14 down to 6.
// [R07] Reserved bits 10:7 always read zero.
// [R08] Manager writes zero to every reserved bit.
// [R09] Bit 6 reports preamble suppression ability, default zero.
// [R10] Setting bit 6 by override lets frames without preamble through.
// [R11] Bit 5 latches negotiation complete, zero while disabled or busy.
// [R12] Bit 3 always reads one.
// [R13] Bit 0 always reads one.
// [R14] Bit 4 latches partner remote fault, cleared by a read.
// [R15] Bit 2 latches low on any link drop.
// [R16] Bit 1 latches jabber when jabber detection is enabled.
// [R17] High latch holds one until read, then follows the live condition.
// [R18] Low latch holds zero until read, then follows the live condition.
`timescale 1ns/1ns
`include "psr_defines.svh"
module psr_status_reg
	import psr_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [4:0] REG_ADDR_IN,
	input wire logic REG_RD_IN,
	input wire logic REG_WR_IN,
	input wire logic [15:0] REG_WDATA_IN,
	output logic [15:0] REG_RDATA_OUT,
	input wire logic OVERRIDE_EN_IN,
	input wire logic AN_ENABLE_IN,
	input wire logic AN_DONE_IN,
	input wire logic REMOTE_FAULT_IN,
	input wire logic LINK_OK_IN,
	input wire logic JABBER_IN,
	input wire logic JABBER_DET_EN_IN,
	output logic [3:0] MODE_ABILITY_OUT,
	output logic PREAMBLE_SUPPRESS_OUT,
	output logic [3:0] RESERVED_TEST_OUT
);

	// ==========================================================
	// Access decode
	function automatic logic psr_hit(input logic strobe,
		input logic [4:0] addr);
		psr_hit = strobe && (addr == `PSR_ADDR);
	endfunction

	wire rd_hit;
	wire wr_hit;
	wire cw_write;

	assign rd_hit = psr_hit(REG_RD_IN, REG_ADDR_IN); // R01
	assign wr_hit = psr_hit(REG_WR_IN, REG_ADDR_IN); // R01
	// Without override the write strobe is dropped entirely
	assign cw_write = wr_hit && OVERRIDE_EN_IN; // R05

	// ==========================================================
	// Override-writable bits 14:6
	psr_cw_type cw_bits;
	psr_cw_type next_cw_bits;

	assign next_cw_bits = cw_write ?
		REG_WDATA_IN[`PSR_CW_HI:`PSR_CW_LO] : cw_bits; // R06

	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			cw_bits <= `PSR_CW_RESET; // R02 R04 R09
		end else begin
			cw_bits <= next_cw_bits;
		end
	end

	// Reserved bits steer test hooks only; the manager keeps them at zero
	assign MODE_ABILITY_OUT = cw_bits[8:5];
	assign RESERVED_TEST_OUT = cw_bits[4:1]; // R08
	assign PREAMBLE_SUPPRESS_OUT = cw_bits[0]; // R10

	// ==========================================================
	// Latching status flags
	wire anc_cond;
	wire jab_cond;
	wire anc_flag;
	wire rf_flag;
	wire link_flag;
	wire jab_flag;
	wire [3:0] flag_cond;
	wire [3:0] flag_out;

	// Disabled negotiation forces the complete flag low
	assign anc_cond = AN_ENABLE_IN && AN_DONE_IN; // R11
	assign jab_cond = JABBER_IN && JABBER_DET_EN_IN; // R16
	assign flag_cond = {anc_cond, REMOTE_FAULT_IN, LINK_OK_IN, jab_cond};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
			psr_sticky_flag #(
				.POL((gi == 1) ? PSR_LATCH_LOW : PSR_LATCH_HIGH) // R15 R18
			) u_flag (
				.clk_in(CORE_CLK_IN),
				.rst_n_in(RST_N_IN),
				.cond_in(flag_cond[gi]),
				.clear_in(rd_hit), // R14 R17 R18
				.flag_out(flag_out[gi])
			);
		end
	endgenerate

	assign anc_flag = flag_out[3] && AN_ENABLE_IN; // R11
	assign rf_flag = flag_out[2]; // R14
	assign link_flag = flag_out[1]; // R15
	assign jab_flag = flag_out[0]; // R16

	// ==========================================================
	// Read path
	psr_word_type status_word;
	psr_word_type next_rdata;

	assign status_word = {
		`PSR_T4_VALUE, // R03
		cw_bits[8:5],
		`PSR_RSV_READ, // R07
		cw_bits[0], // R09
		anc_flag,
		rf_flag,
		`PSR_ANA_VALUE, // R12
		link_flag,
		jab_flag,
		`PSR_EXT_VALUE // R13
	};
	assign next_rdata = rd_hit ? status_word : REG_RDATA_OUT; // R01

	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			REG_RDATA_OUT <= `PSR_RDATA_RESET; // R02
		end else begin
			REG_RDATA_OUT <= next_rdata;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	// Checked from the second reset edge on, once the flops are settled
	a_reset_load: assert property ( // R02 R04 R09
		disable iff (1'h0)
		!RST_N_IN ##1 !RST_N_IN |-> cw_bits == `PSR_CW_RESET &&
		REG_RDATA_OUT == `PSR_RDATA_RESET)
		else $error("reset did not load the defaults");

	a_data_held: assert property ( // R01
		!rd_hit |=> $stable(REG_RDATA_OUT))
		else $error("read data changed without a read");

	a_t4_zero: assert property ( // R03
		rd_hit |=> !REG_RDATA_OUT[`PSR_T4_BIT])
		else $error("bit 15 read as one");

	a_write_locked: assert property ( // R05
		wr_hit && !OVERRIDE_EN_IN |=> $stable(cw_bits))
		else $error("write without override changed the word");

	a_write_taken: assert property ( // R06
		wr_hit && OVERRIDE_EN_IN |=>
		cw_bits == $past(REG_WDATA_IN[`PSR_CW_HI:`PSR_CW_LO]))
		else $error("override write not stored");

	a_rsv_zero: assert property ( // R07
		rd_hit |=> REG_RDATA_OUT[10:7] == 4'h0)
		else $error("reserved bits read nonzero");

	a_preamble_on: assert property ( // R10
		wr_hit && OVERRIDE_EN_IN && REG_WDATA_IN[6] ##1 !wr_hit ##1
		(rd_hit && !wr_hit) |=> REG_RDATA_OUT[6] && PREAMBLE_SUPPRESS_OUT)
		else $error("preamble suppression not enabled");

	a_anc_gated: assert property ( // R11
		rd_hit && !AN_ENABLE_IN |=> !REG_RDATA_OUT[`PSR_ANC_BIT])
		else $error("negotiation complete while disabled");

	a_fixed_ability: assert property ( // R12
		rd_hit |=> REG_RDATA_OUT[`PSR_ANA_BIT])
		else $error("negotiation ability read zero");

	a_fixed_ext: assert property ( // R13
		rd_hit |=> REG_RDATA_OUT[`PSR_EXT_BIT])
		else $error("extended capability read zero");

	a_rf_cleared: assert property ( // R14
		rd_hit ##1 (!rd_hit && !REMOTE_FAULT_IN)[*2] ##1
		(rd_hit && !REMOTE_FAULT_IN) |=> !REG_RDATA_OUT[`PSR_RF_BIT])
		else $error("remote fault not cleared by read");

	a_link_latch: assert property ( // R15 R18
		(!LINK_OK_IN && !rd_hit) ##1 !rd_hit ##1 rd_hit |=>
		!REG_RDATA_OUT[`PSR_LINK_BIT])
		else $error("link drop lost before read");

	a_link_follows: assert property ( // R18
		rd_hit ##1 LINK_OK_IN[*2] ##1 (rd_hit && LINK_OK_IN) |=>
		REG_RDATA_OUT[`PSR_LINK_BIT])
		else $error("link stayed low after a clearing read");

	a_jab_latch: assert property ( // R16 R17
		(jab_cond && !rd_hit) ##1 !rd_hit ##1 rd_hit |=>
		REG_RDATA_OUT[`PSR_JAB_BIT])
		else $error("jabber event lost before read");

	c_override_write: cover property (wr_hit && OVERRIDE_EN_IN);
	c_jabber_read: cover property (jab_cond ##2 rd_hit);
	c_link_drop_read: cover property (!LINK_OK_IN ##1 LINK_OK_IN ##1 rd_hit);
	c_anc_read: cover property (anc_cond ##2 rd_hit);
endmodule

// file: verilog/psr_sticky_flag.sv
/*
 One latching status flag, latching high or latching low.
 Assumes the condition comes from logic on the same clock and that
 clear_in is a one-cycle pulse marking a read of the status word.
*/
`timescale 1ns/1ns
module psr_sticky_flag
	import psr_pkg::*;
#(
	parameter psr_latch_type POL = PSR_LATCH_HIGH
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic cond_in,
	input wire logic clear_in,
	output logic flag_out
);
	logic caught;
	logic next_caught;
	wire event_seen;

	assign event_seen = (POL == PSR_LATCH_HIGH) ? cond_in : ~cond_in;
	// The read shows the live condition too, so clearing here loses nothing
	assign next_caught = clear_in ? 1'h0 : (caught | event_seen);
	assign flag_out = (POL == PSR_LATCH_HIGH) ? (caught | cond_in) :
		(~caught & cond_in);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			caught <= 1'h0;
		end else begin
			caught <= next_caught;
		end
	end
endmodule
